// ==== common/seq_pkg.sv ====
package seq_pkg;
   localparam int          NUM_CH          = 2;
   localparam int          MAX_STEPS       = 64;
   localparam int          STEP_W          = 6;
   localparam int          STEP_CNT_W      = 16;
   localparam int          ENTRY_BYTES     = 8;
   localparam logic [7:0]  HASH_BYTE       = 8'h23;
   localparam logic [7:0]  ASCII_ZERO      = 8'h30;
   // register byte addresses
   localparam logic [7:0]  ADDR_CTRL       = 8'h00;
   localparam logic [7:0]  ADDR_ONCE_COUNT = 8'h04;
   localparam logic [7:0]  ADDR_STATUS     = 8'h08;
   localparam logic [7:0]  ADDR_TRIGGER    = 8'h0C;
   localparam logic [7:0]  ADDR_LOAD_BYTE  = 8'h10;
   localparam logic [7:0]  ADDR_LENGTH     = 8'h14;
   // ctrl fields
   localparam int          CTRL_RUN_BIT    = 0;
   localparam int          CTRL_TYPE_BIT   = 1;
   localparam int          CTRL_ADV_LSB    = 2;
   localparam int          CTRL_SRC_BIT    = 4;
   localparam int          CTRL_CH_BIT     = 5;
   localparam logic [31:0] ONCE_COUNT_RST  = 32'h0000_0001;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;

   typedef enum logic [1:0] {ADV_CONT = 2'd0, ADV_ONCE = 2'd1, ADV_STEP = 2'd2} adv_mode_t;
   typedef enum logic {TYPE_NORMAL = 1'b0, TYPE_ADVANCED = 1'b1} seq_type_t;
   typedef enum logic {SRC_REMOTE = 1'b0, SRC_EXTERNAL = 1'b1} event_src_t;

   typedef struct packed {
      logic [15:0] hold_flag;
      logic [15:0] segment;
      logic [31:0] loops;
   } table_entry_record_t;

   typedef struct packed {
      logic       run;
      seq_type_t  seq_type;
      adv_mode_t  adv;
      event_src_t src;
      logic       channel;
   } ctrl_t;
endpackage : seq_pkg

// ==== rtl/step_sequencer.sv ====
`timescale 1ns/1ps
// Overview of operation
// [R01] normal or advanced sequence type, normal default
// [R02] continuous mode loops the table forever
// [R03] step plays its loop count then advances
// [R04] held step waits for event in continuous/once
// [R05] once mode runs table then idles
// [R06] once repeat count reruns the whole table
// [R07] stepped mode advances only on events
// [R08] stepped mode wraps to first step
// [R09] stepped mode ignores hold flags
// [R10] each event plays full loop count
// [R11] continuous is the reset advance mode
// [R12] status reports advance mode and type
// [R13] load header: hash, digit count, byte count
// [R14] host sends byte count multiple of eight
// [R15] entry: loops, segment, hold flag fields
// [R16] entries numbered in arrival order
// [R17] host sends 3 to 49152 steps; table keeps only the first 64
// [R18] one table per channel, selected only
// [R19] host owns content correctness
// [R20] payload accepts any byte value
// [R21] event source remote trigger or external
// [R22] host keeps segment in 1..32000
// [R23] fields arrive least significant byte first
// [R24] held step finishes loops before event test
module step_sequencer
   import seq_pkg::*;
(
   input  wire logic        clk,            // 10 MHz clock
   input  wire logic        rst,            // async reset, active high
   input  wire logic [7:0]  s_axi_awaddr,   // write address
   input  wire logic        s_axi_awvalid,  // write address valid
   output logic             s_axi_awready,  // write address ready
   input  wire logic [31:0] s_axi_wdata,    // write data
   input  wire logic [3:0]  s_axi_wstrb,    // write strobes
   input  wire logic        s_axi_wvalid,   // write data valid
   output logic             s_axi_wready,   // write data ready
   output logic [1:0]       s_axi_bresp,    // write response
   output logic             s_axi_bvalid,   // write response valid
   input  wire logic        s_axi_bready,   // write response ready
   input  wire logic [7:0]  s_axi_araddr,   // read address
   input  wire logic        s_axi_arvalid,  // read address valid
   output logic             s_axi_arready,  // read address ready
   output logic [31:0]      s_axi_rdata,    // read data
   output logic [1:0]       s_axi_rresp,    // read response
   output logic             s_axi_rvalid,   // read data valid
   input  wire logic        s_axi_rready,   // read data ready
   input  wire logic        event_in,       // external event pin, async
   output logic [15:0]      segment_out,    // segment now played, 0 when idle
   output logic             segment_start,  // pulse at start of each segment play
   output logic             seq_idle,       // sequencer stopped
   input  wire logic        segment_done    // segment player finished one pass
);
   // per-channel table memory
   table_entry_record_t table_mem [NUM_CH][MAX_STEPS];
   logic [STEP_CNT_W-1:0] len_reg [NUM_CH];

   ctrl_t       ctrl_reg;
   logic [31:0] once_count_reg;
   logic        aw_got_reg, w_got_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        trig_pulse, load_pulse;
   logic [7:0]  load_byte;
   logic        bad_addr;

   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aw_got_reg  <= 1'b0;
         w_got_reg   <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_reg  <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (aw_got_reg && w_got_reg)
         begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= bad_addr ? RESP_SLVERR : RESP_OKAY;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   wire wr_go = aw_got_reg && w_got_reg;
   always_comb
   begin
      bad_addr   = 1'b0;
      trig_pulse = 1'b0;
      load_pulse = 1'b0;
      load_byte  = w_data_reg[7:0];
      if (aw_addr_reg == ADDR_CTRL || aw_addr_reg == ADDR_ONCE_COUNT)
         bad_addr = 1'b0;
      else if (aw_addr_reg == ADDR_TRIGGER)
         trig_pulse = wr_go && w_strb_reg[0] && w_data_reg[0];
      else if (aw_addr_reg == ADDR_LOAD_BYTE)
         load_pulse = wr_go && w_strb_reg[0];
      else if (aw_addr_reg == ADDR_STATUS || aw_addr_reg == ADDR_LENGTH)
         bad_addr = 1'b0;
      else
         bad_addr = 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_reg       <= '{run: 1'b0, seq_type: TYPE_NORMAL, adv: ADV_CONT,
                             src: SRC_REMOTE, channel: 1'b0}; // R01 R11 R21
         once_count_reg <= ONCE_COUNT_RST;
      end
      else if (wr_go && aw_addr_reg == ADDR_CTRL && w_strb_reg[0])
      begin
         ctrl_reg.run      <= w_data_reg[CTRL_RUN_BIT];
         ctrl_reg.seq_type <= seq_type_t'(w_data_reg[CTRL_TYPE_BIT]); // R01
         ctrl_reg.adv      <= (w_data_reg[CTRL_ADV_LSB+:2] == 2'd3) ? ADV_CONT
                              : adv_mode_t'(w_data_reg[CTRL_ADV_LSB+:2]);
         ctrl_reg.src      <= event_src_t'(w_data_reg[CTRL_SRC_BIT]); // R21
         ctrl_reg.channel  <= w_data_reg[CTRL_CH_BIT];
      end
      else if (wr_go && aw_addr_reg == ADDR_ONCE_COUNT && w_strb_reg == 4'hF)
         once_count_reg <= w_data_reg;
   end

   // binary table loader: '#', digit count, decimal byte count, payload
   typedef enum {LD_IDLE, LD_NDIG, LD_COUNT, LD_DATA} ld_state_t;
   ld_state_t   ld_state;
   logic [3:0]  digits_left;
   logic [31:0] bytes_left;
   logic [2:0]  byte_idx;
   logic [55:0] entry_acc;
   logic [STEP_CNT_W-1:0] wr_step;
   logic        ld_ch;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ld_state    <= LD_IDLE;
         digits_left <= 4'h0;
         bytes_left  <= 32'h0000_0000;
         byte_idx    <= 3'h0;
         entry_acc   <= 56'h0;
         wr_step     <= '0;
         ld_ch       <= 1'b0;
         len_reg     <= '{default: '0};
      end
      else if (load_pulse)
      begin
         case (ld_state)
            LD_IDLE:
               if (load_byte == HASH_BYTE) // R13
               begin
                  ld_state <= LD_NDIG;
                  ld_ch    <= ctrl_reg.channel; // R18
               end
            LD_NDIG:
            begin
               digits_left <= 4'(load_byte - ASCII_ZERO); // R13
               bytes_left  <= 32'h0000_0000;
               ld_state    <= (load_byte == ASCII_ZERO) ? LD_IDLE : LD_COUNT;
            end
            LD_COUNT:
            begin
               bytes_left  <= 32'(bytes_left * 10 + 32'(load_byte - ASCII_ZERO)); // R13
               digits_left <= digits_left - 4'h1;
               byte_idx    <= 3'h0;
               wr_step     <= '0;
               if (digits_left == 4'h1)
                  ld_state <= LD_DATA;
            end
            LD_DATA:
            begin
               // any byte value is payload here, '#' included  R20
               entry_acc <= {load_byte, entry_acc[55:8]}; // R23
               byte_idx  <= byte_idx + 3'h1;
               bytes_left <= bytes_left - 32'h1;
               if (byte_idx == 3'(ENTRY_BYTES - 1)) // R15
               begin
                  if (wr_step < STEP_CNT_W'(MAX_STEPS))
                     table_mem[ld_ch][wr_step[STEP_W-1:0]] <= {load_byte, entry_acc}; // R16
                  wr_step <= wr_step + 1'b1;
                  len_reg[ld_ch] <= wr_step + 1'b1; // R16
               end
               if (bytes_left == 32'h1)
                  ld_state <= LD_IDLE;
            end
            default: ld_state <= LD_IDLE;
         endcase
      end
   end

   // external event: two flops then edge detect
   logic ev_s1, ev_s2, ev_s3;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         {ev_s1, ev_s2, ev_s3} <= 3'b000;
      else
         {ev_s1, ev_s2, ev_s3} <= {event_in, ev_s1, ev_s2};
   end
   wire ev_valid = (ctrl_reg.src == SRC_EXTERNAL) ? (ev_s2 && !ev_s3) : trig_pulse; // R21

   // playback
   typedef enum {PB_IDLE, PB_PLAY, PB_WAIT_EV} pb_state_t;
   pb_state_t   pb_state;
   logic [STEP_W-1:0] cur_step;
   logic [31:0] loop_cnt, once_left;
   logic        play_ch;
   table_entry_record_t cur;
   logic [STEP_CNT_W-1:0] cur_len;
   assign cur     = table_mem[play_ch][cur_step];
   assign cur_len = len_reg[play_ch];
   wire last_step = (STEP_CNT_W'(cur_step) + 1'b1 >= cur_len);
   wire [STEP_W-1:0] nxt_step = last_step ? '0 : cur_step + 1'b1;
   wire step_held = (cur.hold_flag != 16'h0) && (ctrl_reg.adv != ADV_STEP); // R04 R09
   assign seq_idle = (pb_state == PB_IDLE);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pb_state      <= PB_IDLE;
         cur_step      <= '0;
         loop_cnt      <= 32'h0;
         once_left     <= 32'h0;
         play_ch       <= 1'b0;
         segment_out   <= 16'h0;
         segment_start <= 1'b0;
      end
      else
      begin
         segment_start <= 1'b0;
         if (!ctrl_reg.run || cur_len == '0)
         begin
            pb_state    <= PB_IDLE;
            play_ch     <= ctrl_reg.channel;
            once_left   <= 32'h0;
            cur_step    <= '0;
            segment_out <= 16'h0;
         end
         else
         case (pb_state)
            PB_IDLE:
               if (cur_step == '0 && segment_out == 16'h0 && once_left != 32'hFFFF_FFFF)
               begin
                  once_left <= (once_count_reg == 32'h0) ? 32'h1 : once_count_reg; // R06
                  loop_cnt  <= 32'h1;
                  pb_state  <= (ctrl_reg.adv == ADV_STEP) ? PB_WAIT_EV : PB_PLAY; // R07
                  if (ctrl_reg.adv != ADV_STEP)
                  begin
                     segment_out   <= cur.segment;
                     segment_start <= 1'b1;
                  end
               end
            PB_PLAY:
               if (segment_done)
               begin
                  if (loop_cnt < cur.loops) // R03 R10
                  begin
                     loop_cnt      <= loop_cnt + 32'h1;
                     segment_start <= 1'b1;
                  end
                  else if (ctrl_reg.adv == ADV_STEP) // R10
                  begin
                     cur_step <= nxt_step; // R08
                     loop_cnt <= 32'h1;
                     pb_state <= PB_WAIT_EV; // R07
                  end
                  else if (step_held) // R24
                     pb_state <= PB_WAIT_EV; // R04
                  else if (last_step && ctrl_reg.adv == ADV_ONCE && once_left <= 32'h1)
                  begin
                     pb_state    <= PB_IDLE; // R05
                     once_left   <= 32'hFFFF_FFFF;
                     segment_out <= 16'h0;
                     cur_step    <= '1;
                  end
                  else
                  begin
                     if (last_step && ctrl_reg.adv == ADV_ONCE)
                        once_left <= once_left - 32'h1; // R06
                     cur_step      <= nxt_step; // R02
                     loop_cnt      <= 32'h1;
                     segment_out   <= table_mem[play_ch][nxt_step].segment;
                     segment_start <= 1'b1;
                  end
               end
            PB_WAIT_EV:
               if (ev_valid)
               begin
                  if (ctrl_reg.adv == ADV_STEP)
                  begin
                     segment_out   <= cur.segment; // R07
                     segment_start <= 1'b1;
                     pb_state      <= PB_PLAY;
                  end
                  else if (last_step && ctrl_reg.adv == ADV_ONCE && once_left <= 32'h1)
                  begin
                     pb_state    <= PB_IDLE; // R05
                     once_left   <= 32'hFFFF_FFFF;
                     segment_out <= 16'h0;
                     cur_step    <= '1;
                  end
                  else
                  begin
                     if (last_step && ctrl_reg.adv == ADV_ONCE)
                        once_left <= once_left - 32'h1;
                     cur_step      <= nxt_step; // R04
                     loop_cnt      <= 32'h1;
                     segment_out   <= table_mem[play_ch][nxt_step].segment;
                     segment_start <= 1'b1;
                     pb_state      <= PB_PLAY;
                  end
               end
            default: pb_state <= PB_IDLE;
         endcase
      end
   end

   // read channel, one cycle after address accepted
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (s_axi_araddr == ADDR_CTRL)
            s_axi_rdata <= 32'({ctrl_reg.channel, ctrl_reg.src, ctrl_reg.adv,
                                ctrl_reg.seq_type, ctrl_reg.run});
         else if (s_axi_araddr == ADDR_ONCE_COUNT)
            s_axi_rdata <= once_count_reg;
         else if (s_axi_araddr == ADDR_STATUS)
            s_axi_rdata <= {6'h0, segment_out, seq_idle, cur_step,
                            ctrl_reg.seq_type, ctrl_reg.adv}; // R12
         else if (s_axi_araddr == ADDR_LENGTH)
            s_axi_rdata <= 32'(len_reg[ctrl_reg.channel]);
         else if (s_axi_araddr == ADDR_TRIGGER || s_axi_araddr == ADDR_LOAD_BYTE)
            s_axi_rdata <= 32'h0;
         else
         begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule : step_sequencer

// ==== bench/seg_player.sv ====
`timescale 1ns/1ps
module seg_player
(
   input  wire logic clk,            // clock
   input  wire logic rst,            // async reset, active high
   input  wire logic segment_start,  // segment play begins
   input  wire logic slow,           // answer after six cycles instead of two
   output logic      segment_done    // one pass finished
);
   logic [2:0] cnt_reg;

   // one pass lasts two cycles or six from segment_start to segment_done; a real player never ends before it starts
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg      <= 3'h0;
         segment_done <= 1'b0;
      end
      else
      begin
         segment_done <= (cnt_reg == 3'h1);
         if (segment_start)
            cnt_reg <= slow ? 3'h5 : 3'h1;
         else if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
      end
   end
endmodule : seg_player

// ==== bench/step_sequencer_props.sv ====
`timescale 1ns/1ps
module step_sequencer_props
(
   input wire logic        clk,            // clock
   input wire logic        rst,            // async reset
   input wire logic        s_axi_awvalid,  // write address valid
   input wire logic        s_axi_awready,  // write address ready
   input wire logic        s_axi_wvalid,   // write data valid
   input wire logic        s_axi_wready,   // write data ready
   input wire logic        s_axi_bvalid,   // write response valid
   input wire logic        s_axi_arvalid,  // read address valid
   input wire logic        s_axi_arready,  // read address ready
   input wire logic        s_axi_rvalid,   // read data valid
   input wire logic [15:0] segment_out,    // segment now played
   input wire logic        segment_start,  // play start pulse
   input wire logic        seq_idle        // sequencer stopped
);
   wire logic w_taken = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_idle_seg; seq_idle |-> segment_out == 16'h0000; endproperty
   a_idle_seg: assert property (p_idle_seg) else $error("segment shown while idle");
   property p_idle_nostart; seq_idle |-> !segment_start; endproperty
   a_idle_nostart: assert property (p_idle_nostart) else $error("start while idle");
   property p_seg_change; !$stable(segment_out) |-> segment_start || seq_idle; endproperty
   a_seg_change: assert property (p_seg_change) else $error("segment changed mid play");
   property p_start_seg; segment_start |-> segment_out != 16'h0000; endproperty
   a_start_seg: assert property (p_start_seg) else $error("start without segment");
   property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
   property p_r_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_refuse: assert property (p_r_refuse) else $error("read taken while busy");
   property p_w_answer; w_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid; endproperty
   a_w_answer: assert property (p_w_answer) else $error("write not answered");
   property p_b_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_b_refuse: assert property (p_b_refuse) else $error("write taken while busy");

   c_start: cover property (segment_start);
   c_idle: cover property ($rose(seq_idle));
   c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule : step_sequencer_props

bind step_sequencer step_sequencer_props u_props (.clk(clk), .rst(rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .segment_out(segment_out),
   .segment_start(segment_start), .seq_idle(seq_idle));

// ==== bench/test_step_sequencer.sv ====
`timescale 1ns/1ps
module test_step_sequencer
   import seq_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        event_in = 1'b0;
   logic        slow = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        segment_start, seq_idle, segment_done;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] segment_out;
   logic [31:0] lfsr_reg = 32'hD8EF723F;
   logic [65:0] rexp;
   logic [15:0] seg_q[$];
   logic [65:0] rd_q[$];
   logic [1:0]  bq[$];
   logic [31:0] loops_a[2][4];
   logic [15:0] seg_a[2][4];
   logic [15:0] hold_a[2][4];
   int          miscompares = 0;
   int          cmp_count = 0;
   int          start_cnt = 0;

   always #50 clk = ~clk;

   step_sequencer u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .event_in(event_in), .segment_out(segment_out),
      .segment_start(segment_start), .seq_idle(seq_idle), .segment_done(segment_done));
   seg_player u_player (.clk(clk), .rst(rst), .segment_start(segment_start), .slow(slow),
      .segment_done(segment_done));

   function automatic logic [31:0] ctl(input int r, input int t, input logic [1:0] a,
                                       input int s, input int c);
      return {26'h0, c[0], s[0], a, t[0], r[0]};
   endfunction : ctl

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test

   // leading edge wait keeps two tasks from driving bready in one time step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bq.push_back((a[1:0] != 2'h0 || a > ADDR_LENGTH) ? RESP_SLVERR : RESP_OKAY);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         #1;
      end
      while (s_axi_awvalid || s_axi_wvalid);
      do
         @(posedge clk);
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      @(posedge clk);
      rd_q.push_back({r, m, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
         @(posedge clk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge clk);
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic push_step(input int c, input int k);
      repeat (loops_a[c][k]) seg_q.push_back(seg_a[c][k]);
   endtask : push_step

   task automatic wait_q();
      int n;
      n = 0;
      while (seg_q.size() != 0 && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      check(32'(seg_q.size()), 32'h0);
      repeat (12) @(negedge clk);
   endtask : wait_q

   task automatic dwell();
      int n0;
      @(negedge clk);
      n0 = start_cnt;
      repeat (30) @(negedge clk);
      check(32'(start_cnt), 32'(n0));
   endtask : dwell

   task automatic load(input int c, input int n);
      logic [63:0] e;
      logic [7:0]  hdr[4];
      hdr = '{HASH_BYTE, ASCII_ZERO + 8'h2, ASCII_ZERO + 8'(n * 8 / 10), ASCII_ZERO + 8'(n * 8 % 10)};
      wr(ADDR_CTRL, ctl(0, 0, 2'h0, 0, c[0]));
      foreach (hdr[i]) wr(ADDR_LOAD_BYTE, {24'h0, hdr[i]});
      for (int k = 0; k < n; k++)
      begin
         e = {hold_a[c][k], seg_a[c][k], loops_a[c][k]};
         for (int b = 0; b < 8; b++)
            wr(ADDR_LOAD_BYTE, {24'h0, e[8 * b +: 8]});
      end
      rd(ADDR_LENGTH, 32'(n), 32'hFFFFFFFF, RESP_OKAY);
   endtask : load

   always @(posedge clk)
   begin
      if (segment_start)
         start_cnt++;
      if (segment_start && seg_q.size() != 0)
         check(32'(segment_out), 32'(seg_q.pop_front()));
      if (s_axi_bvalid && s_axi_bready)
         check(32'(s_axi_bresp), 32'(bq.pop_front()));
      if (s_axi_rvalid && s_axi_rready)
      begin
         rexp = rd_q.pop_front();
         check(s_axi_rdata & rexp[63:32], rexp[31:0]);
         check(32'(s_axi_rresp), 32'(rexp[65:64]));
      end
   end

   initial
   begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(ADDR_STATUS, 32'h0000_0200, 32'h0000_0207, RESP_OKAY);
      rd(8'h18, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      wr(8'h18, 32'h0);
      wr(ADDR_CTRL, ctl(0, 1, 2'h0, 0, 0));
      rd(ADDR_STATUS, 32'h4, 32'h4, RESP_OKAY);
      for (int m = 0; m < 4; m++)
      begin
         wr(ADDR_CTRL, ctl(0, 0, m[1:0], 0, 0));
         rd(ADDR_STATUS, 32'(m % 3), 32'h3, RESP_OKAY);
      end
      for (int i = 0; i < 8; i++)
      begin
         lfsr_reg = lfsr_next(lfsr_reg);
         loops_a[i / 4][i % 4] = 32'h1 + 32'(lfsr_reg[1:0] % 2'h3);
         seg_a[i / 4][i % 4] = 16'(lfsr_reg[31:8] % 24'd32000 + 24'h1);
         hold_a[i / 4][i % 4] = 16'h0;
      end
      seg_a[0][0] = 16'h2323;
      hold_a[1][1] = 16'h0001;
      load(0, 3);
      load(1, 4);
      wr(ADDR_CTRL, ctl(0, 0, 2'h0, 0, 0));
      rd(ADDR_LENGTH, 32'h3, 32'hFFFFFFFF, RESP_OKAY);
      for (int p = 0; p < 6; p++) push_step(0, p % 3);
      wr(ADDR_CTRL, ctl(1, 0, 2'h0, 0, 0));
      wait_q();
      wr(ADDR_CTRL, ctl(0, 0, 2'h1, 0, 0));
      slow <= 1'b1;
      wr(ADDR_ONCE_COUNT, 32'h2);
      for (int p = 0; p < 6; p++) push_step(0, p % 3);
      wr(ADDR_CTRL, ctl(1, 0, 2'h1, 0, 0));
      wait_q();
      check(32'(seq_idle), 32'h1);
      dwell();
      wr(ADDR_CTRL, ctl(0, 0, 2'h0, 0, 1));
      push_step(1, 0);
      push_step(1, 1);
      wr(ADDR_CTRL, ctl(1, 0, 2'h0, 0, 1));
      wait_q();
      dwell();
      push_step(1, 2);
      push_step(1, 3);
      wr(ADDR_TRIGGER, 32'h1);
      wait_q();
      wr(ADDR_CTRL, ctl(0, 0, 2'h2, 1, 1));
      wr(ADDR_CTRL, ctl(1, 0, 2'h2, 1, 1));
      dwell();
      for (int e = 0; e < 5; e++)
      begin
         push_step(1, e % 4);
         @(posedge clk);
         event_in <= 1'b1;
         repeat (4) @(posedge clk);
         event_in <= 1'b0;
         wait_q();
      end
      dwell();
      stop_test();
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      miscompares++;
      stop_test();
   end
endmodule : test_step_sequencer
